// File: pmr_pkg.sv
// Shared constants and types for the management register bank.
// Assumes a single 100 MHz clock and 16-bit management words.
package pmr_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int DATA_W    = 16;
  localparam int ADDR_W    = 5;
  localparam int REG_COUNT = 13;

  typedef logic [DATA_W-1:0] pmr_word_t;
  typedef logic [ADDR_W-1:0] pmr_addr_t;
  typedef logic [3:0]        pmr_idx_t;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam pmr_addr_t ADDR_BASIC_CONTROL   = 5'h00;
  localparam pmr_addr_t ADDR_BASIC_STATUS    = 5'h01;
  localparam pmr_addr_t ADDR_IDENT_HIGH      = 5'h02;
  localparam pmr_addr_t ADDR_IDENT_LOW       = 5'h03;
  localparam pmr_addr_t ADDR_NEG_ADVERTISE   = 5'h04;
  localparam pmr_addr_t ADDR_PARTNER_ABILITY = 5'h05;
  localparam pmr_addr_t ADDR_NEG_EXPANSION   = 5'h06;
  localparam pmr_addr_t ADDR_NP_TRANSMIT     = 5'h07;
  localparam pmr_addr_t ADDR_NP_PARTNER      = 5'h08;
  localparam pmr_addr_t ADDR_EXT_CTRL_ONE    = 5'h10;
  localparam pmr_addr_t ADDR_QUICK_POLL      = 5'h11;
  localparam pmr_addr_t ADDR_TEN_MEG         = 5'h12;
  localparam pmr_addr_t ADDR_EXT_CTRL_TWO    = 5'h13;

  // Storage slot of each implemented address, slot 12 first
  localparam pmr_addr_t [REG_COUNT-1:0] REG_ADDR = {
    ADDR_EXT_CTRL_TWO, ADDR_TEN_MEG, ADDR_QUICK_POLL, ADDR_EXT_CTRL_ONE,
    ADDR_NP_PARTNER, ADDR_NP_TRANSMIT, ADDR_NEG_EXPANSION,
    ADDR_PARTNER_ABILITY, ADDR_NEG_ADVERTISE, ADDR_IDENT_LOW,
    ADDR_IDENT_HIGH, ADDR_BASIC_STATUS, ADDR_BASIC_CONTROL};

  localparam pmr_idx_t IDX_CONTROL      = 4'h0;
  localparam pmr_idx_t IDX_STATUS       = 4'h1;
  localparam pmr_idx_t IDX_IDENT_HIGH   = 4'h2;
  localparam pmr_idx_t IDX_IDENT_LOW    = 4'h3;
  localparam pmr_idx_t IDX_NP_TRANSMIT  = 4'h7;
  localparam pmr_idx_t IDX_EXT_CTRL_ONE = 4'h9;
  localparam pmr_idx_t IDX_TEN_MEG      = 4'hb;

  // ----------------------------------------------------------------
  // Per-slot reset values and access classes (slot 12 first)
  // ----------------------------------------------------------------
  localparam pmr_word_t [REG_COUNT-1:0] RESET_VAL = {
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h3000};
  localparam pmr_word_t [REG_COUNT-1:0] RW_MASK = {
    16'hffff, 16'hfffe, 16'h0000, 16'hffff, 16'h0000, 16'hffff,
    16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'h0000, 16'h0000, 16'hff80};
  localparam pmr_word_t [REG_COUNT-1:0] GATED_MASK = {
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0040, 16'h0000};
  localparam pmr_word_t [REG_COUNT-1:0] W0_MASK = {
    16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam pmr_word_t [REG_COUNT-1:0] STORED_MASK = RW_MASK | GATED_MASK | W0_MASK;

  // ----------------------------------------------------------------
  // Field positions and fixed answers
  // ----------------------------------------------------------------
  localparam int        SW_RESET_BIT  = 15;
  localparam int        ISOLATE_BIT   = 10;
  localparam int        OVERRIDE_BIT  = 15;
  localparam int        DEV_ADDR_LSB  = 6;
  localparam int        DEV_ADDR_W    = 5;
  localparam pmr_word_t UNMAPPED_READ = 16'hffff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 10;
  localparam int STRAP_SETTLE_NS  = 40;
  localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PH_LOAD, PH_RUN, PH_SOFT} pmr_phase_t;

  typedef struct packed {
    pmr_phase_t                 phase;
    pmr_word_t [REG_COUNT-1:0]  regs;
    pmr_word_t                  rdData;
    logic                       rdValid;
  } pmr_bank_state_t;

  typedef struct packed {
    logic [DEV_ADDR_W-1:0] s1;
    logic [DEV_ADDR_W-1:0] s2;
    logic [DEV_ADDR_W-1:0] s3;
    logic [2:0]            cnt;
    logic [DEV_ADDR_W-1:0] devAddr;
    logic                  valid;
  } pmr_strap_state_t;

endpackage

// File: pmr_register_bank.sv
// Management register bank: 32-address map on 13 slots, access classes, defaults.
// Assumes a frame engine on the same clock issues one-cycle strobes.
`timescale 1ns/1ns
`default_nettype none
module pmr_register_bank import pmr_pkg::*; #(
  parameter pmr_word_t IDENT_HIGH = 16'h1234,  // Arbitrary identity value
  parameter pmr_word_t IDENT_LOW  = 16'h5678   // Arbitrary identity value
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      resetn,
  // Address strap pins
  input  wire logic                      addrStrapBit0Led,
  input  wire logic                      addrStrapBit1Led,
  input  wire logic                      addrStrapBit2Led,
  input  wire logic                      addrStrapBit3Led,
  input  wire logic                      addrStrapBit4Led,
  // Register access from frame engine
  input  wire pmr_addr_t                 registerSelectField,
  input  wire logic                      rdStrobe,
  input  wire logic                      wrStrobe,
  input  wire pmr_word_t                 wrData,
  output logic                           busy,
  output logic                           rdValid,
  output pmr_word_t                      rdData,
  // Core side
  input  wire pmr_word_t [REG_COUNT-1:0] hwStatus,
  input  wire pmr_word_t [REG_COUNT-1:0] hwSetBits,
  output pmr_word_t [REG_COUNT-1:0]      ctrlWord,
  output logic [DEV_ADDR_W-1:0]          deviceAddressBits,
  output logic                           softResetPulse
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pmr_strap_if      strap ();   // Latched strap address
  pmr_bank_state_t  st;         // Registered state
  pmr_bank_state_t  next_st;    // Next state
  logic             rdHit;      // Read hits an implemented slot
  pmr_idx_t         rdIdx;      // Read slot
  logic             wrHit;      // Write hits an implemented slot
  pmr_idx_t         wrIdx;      // Write slot
  logic             running;    // Accesses accepted
  logic             ovr;        // Override armed before this write
  logic             loadNow;    // Defaults load this cycle
  logic             wrTaken;    // Implemented write accepted

  // ----------------------------------------------------------------
  // Strap sampler
  // ----------------------------------------------------------------
  pmr_strap_sampler u_strap (
    .clk       (clk),
    .resetn    (resetn),
    .strapPins ({addrStrapBit4Led, addrStrapBit3Led, addrStrapBit2Led,
                 addrStrapBit1Led, addrStrapBit0Led}),
    .strap     (strap.sampler)
  );

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Address to slot; bit 4 of the result is the hit flag
  function automatic logic [4:0] decodeAddr(input pmr_addr_t a);
    logic [4:0] res;
    res = 5'h00;
    for (int k = 0; k < REG_COUNT; k++) begin
      if (REG_ADDR[k] == a) begin
        res = {1'b1, 4'(k)};
      end
    end
    return res;
  endfunction

  // Word seen by a read: stored bits from flops, identity words from parameters, the rest live
  function automatic pmr_word_t readWord(input pmr_idx_t i,
                                         input pmr_word_t held,
                                         input pmr_word_t hw);
    pmr_word_t res;
    res = (held & STORED_MASK[i]) | (hw & ~STORED_MASK[i]);
    if (i == IDX_IDENT_HIGH) begin
      res = IDENT_HIGH;
    end else if (i == IDX_IDENT_LOW) begin
      res = IDENT_LOW;
    end
    return res;
  endfunction

  // New stored value of one slot under a management write
  function automatic pmr_word_t applyWrite(input pmr_idx_t i,
                                           input pmr_word_t old,
                                           input pmr_word_t wd,
                                           input logic armed);
    pmr_word_t res;
    res = (old & ~RW_MASK[i]) | (wd & RW_MASK[i]);
    if (armed) begin
      res = (res & ~GATED_MASK[i]) | (wd & GATED_MASK[i]);
    end
    res = res & (~W0_MASK[i] | wd);
    res = (res & STORED_MASK[i]) | (old & ~STORED_MASK[i]);
    return res;
  endfunction

  // Defaults with strap-derived fields filled in
  function automatic pmr_word_t [REG_COUNT-1:0] defaultRegs(
    input logic [DEV_ADDR_W-1:0] addr);
    pmr_word_t [REG_COUNT-1:0] res;
    res = RESET_VAL;
    res[IDX_EXT_CTRL_ONE][DEV_ADDR_LSB +: DEV_ADDR_W] = addr;
    res[IDX_CONTROL][ISOLATE_BIT] = (addr == '0);
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // five-bit select
  assign {rdHit, rdIdx} = decodeAddr(registerSelectField);
  assign {wrHit, wrIdx} = decodeAddr(registerSelectField);
  assign running = (st.phase == PH_RUN);
  assign ovr     = st.regs[IDX_EXT_CTRL_ONE][OVERRIDE_BIT];
  assign wrTaken = running && wrStrobe && wrHit;
  assign loadNow = ((st.phase == PH_LOAD) && strap.valid) || (st.phase == PH_SOFT);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st         = st;
    next_st.rdValid = 1'b0;
    // Core sets zero-only bits every cycle except those in which defaults load
    for (int i = 0; i < REG_COUNT; i++) begin
      next_st.regs[i] = st.regs[i] | (hwSetBits[i] & W0_MASK[i]);
    end
    case (st.phase)
      // Hold off until straps are latched
      PH_LOAD: begin
        if (strap.valid) begin
          next_st.regs  = defaultRegs(strap.devAddr);
          next_st.phase = PH_RUN;
        end
      end
      // Software reset reuses straps caught at hardware reset
      PH_SOFT: begin
        next_st.regs  = defaultRegs(strap.devAddr);
        next_st.phase = PH_RUN;
      end
      PH_RUN: begin
        // Reads see the value before a same-cycle write
        if (rdStrobe) begin
          next_st.rdValid = 1'b1;
          if (rdHit) begin
            next_st.rdData = readWord(rdIdx, st.regs[rdIdx], hwStatus[rdIdx]);
          end else begin
            next_st.rdData = UNMAPPED_READ;
          end
        end
        if (wrTaken) begin
          for (int i = 0; i < REG_COUNT; i++) begin
            if (4'(i) == wrIdx) begin
              // Hardware set wins over a written zero
              next_st.regs[i] = applyWrite(4'(i), st.regs[i], wrData, ovr)
                                | (hwSetBits[i] & W0_MASK[i]);
            end
          end
          // armed only by the earlier write
          if (wrIdx != IDX_EXT_CTRL_ONE) begin
            next_st.regs[IDX_EXT_CTRL_ONE][OVERRIDE_BIT] = 1'b0;
          end
          // Software reset request
          if ((wrIdx == IDX_CONTROL) && wrData[SW_RESET_BIT]) begin
            next_st.phase = PH_SOFT;
          end
        end
      end
      default: begin
        next_st.phase = PH_LOAD;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // override and all storage start at zero, loaded after straps
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // sixteen-bit words
  assign rdData            = st.rdData;
  assign rdValid           = st.rdValid;
  assign busy              = !running;
  assign ctrlWord          = st.regs;
  assign deviceAddressBits = st.regs[IDX_EXT_CTRL_ONE][DEV_ADDR_LSB +: DEV_ADDR_W];
  assign softResetPulse    = (st.phase == PH_SOFT);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // all ones
  a_unmapped_read:
  assert property (@(posedge clk) disable iff (!resetn)
    running && rdStrobe && !rdHit |=> rdValid && (rdData == UNMAPPED_READ))
    else $error("unmapped read not all ones");

  a_unmapped_write:
  assert property (@(posedge clk) disable iff (!resetn)
    running && wrStrobe && !wrHit |=> $stable(st.regs & ~W0_MASK))
    else $error("unmapped write changed a register");

  a_ro_kept:
  assert property (@(posedge clk) disable iff (!resetn)
    wrTaken |=> ((st.regs[$past(wrIdx)] ^ $past(st.regs[wrIdx]))
                 & ~STORED_MASK[$past(wrIdx)]) == 16'h0000)
    else $error("read-only bit changed by write");

  a_rw_stores:
  assert property (@(posedge clk) disable iff (!resetn)
    wrTaken && (wrIdx == IDX_NP_TRANSMIT)
    |=> st.regs[IDX_NP_TRANSMIT] == $past(wrData))
    else $error("read/write register lost written value");

  a_zero_only:
  assert property (@(posedge clk) disable iff (!resetn)
    wrTaken && (wrIdx == IDX_TEN_MEG)
    && ((st.regs[IDX_TEN_MEG] & W0_MASK[IDX_TEN_MEG]) == 16'h0000)
    && ((hwSetBits[IDX_TEN_MEG] & W0_MASK[IDX_TEN_MEG]) == 16'h0000)
    |=> (st.regs[IDX_TEN_MEG] & W0_MASK[IDX_TEN_MEG]) == 16'h0000)
    else $error("zero-only bit set by write");

  a_gated_blocked:
  assert property (@(posedge clk) disable iff (!resetn)
    wrTaken && (wrIdx == IDX_STATUS) && !ovr
    |=> ((st.regs[IDX_STATUS] ^ $past(st.regs[IDX_STATUS]))
         & GATED_MASK[IDX_STATUS]) == 16'h0000)
    else $error("gated bit changed without override");

  a_gated_applies:
  assert property (@(posedge clk) disable iff (!resetn)
    wrTaken && (wrIdx == IDX_STATUS) && ovr
    |=> (st.regs[IDX_STATUS] & GATED_MASK[IDX_STATUS])
        == ($past(wrData) & GATED_MASK[IDX_STATUS]))
    else $error("gated bit not written under override");

  a_override_clears:
  assert property (@(posedge clk) disable iff (!resetn)
    wrTaken && (wrIdx != IDX_EXT_CTRL_ONE) |=> !ovr)
    else $error("override not cleared by write");

  a_override_reset:
  assert property (@(posedge clk) disable iff (!resetn)
    loadNow |=> !ovr && running)
    else $error("override set after reset load");

  a_defaults_load:
  assert property (@(posedge clk) disable iff (!resetn)
    loadNow |=> st.regs[IDX_NP_TRANSMIT] == RESET_VAL[IDX_NP_TRANSMIT])
    else $error("default not loaded");

  a_strap_addr:
  assert property (@(posedge clk) disable iff (!resetn)
    loadNow |=> (deviceAddressBits == strap.devAddr)
    && (st.regs[IDX_CONTROL][ISOLATE_BIT] == (strap.devAddr == '0)))
    else $error("strap address not loaded");

  a_override_held:
  assert property (@(posedge clk) disable iff (!resetn)
    running && wrStrobe && !wrHit && ovr |=> ovr)
    else $error("unmapped write consumed override");

  // armed by its own write only
  a_override_arms:
  assert property (@(posedge clk) disable iff (!resetn)
    wrTaken && (wrIdx == IDX_EXT_CTRL_ONE)
    |=> ovr == $past(wrData[OVERRIDE_BIT]))
    else $error("override not taken from write");

  a_read_answer:
  assert property (@(posedge clk) disable iff (!resetn)
    running && rdStrobe && rdHit && (rdIdx == IDX_NP_TRANSMIT)
    |=> rdValid && (rdData == $past(st.regs[IDX_NP_TRANSMIT])))
    else $error("read returned wrong word");

  a_read_pulse:
  assert property (@(posedge clk) disable iff (!resetn)
    rdValid |-> $past(running && rdStrobe))
    else $error("read answer without accepted read");

  a_strap_latched:
  assert property (@(posedge clk) disable iff (!resetn)
    strap.valid |=> strap.valid && $stable(strap.devAddr))
    else $error("strap address moved after latch");

endmodule
`default_nettype wire

// File: pmr_sta_model.sv
// Management controller model: issues one-cycle register strobes.
// Assumes the bank answers a read just after the edge that takes it.
`timescale 1ns/1ns
`default_nettype none
module pmr_sta_model import pmr_pkg::*; (
  // Clock and bank status
  input  wire logic      clk,
  input  wire logic      busy,
  input  wire logic      rdValid,
  input  wire pmr_word_t rdData,
  // Requests
  output logic           rdStrobe,
  output logic           wrStrobe,
  output pmr_addr_t      sel,
  output pmr_word_t      wrData
);
  // Quiet bus at time zero
  initial begin
    rdStrobe = 1'b0;
    wrStrobe = 1'b0;
    sel      = 5'h00;
    wrData   = 16'h0000;
  end

  // Gap of one edge, then poll busy under a bound
  task automatic idle_wait();
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic wr(input pmr_addr_t a, input pmr_word_t d);
    idle_wait();
    sel      = a;
    wrData   = d;
    wrStrobe = 1'b1;
    @(posedge clk);
    #1;
    wrStrobe = 1'b0;
    // Released lines show the inverse, never a stale match
    sel      = ~a;
    wrData   = ~d;
  endtask

  // Read answer is taken one edge after the request
  task automatic rd(input pmr_addr_t a, output pmr_word_t d, output logic v);
    idle_wait();
    sel      = a;
    rdStrobe = 1'b1;
    @(posedge clk);
    #1;
    rdStrobe = 1'b0;
    sel      = ~a;
    v        = rdValid;
    d        = rdData;
  endtask
endmodule
`default_nettype wire

// File: pmr_strap_if.sv
// Carrier for the latched strap address between sampler and bank.
// Assumes both ends share one clock.
`timescale 1ns/1ns
`default_nettype none
interface pmr_strap_if;
  import pmr_pkg::*;
  logic [DEV_ADDR_W-1:0] devAddr;  // Latched strap levels
  logic                  valid;    // Latch complete
  modport sampler (output devAddr, output valid);
  modport bank    (input devAddr, input valid);
endinterface
`default_nettype wire

// File: pmr_strap_sampler.sv
// Strap sampler: catches the five address pins after reset release.
// Assumes pins are asynchronous and static around reset.
`timescale 1ns/1ns
`default_nettype none
module pmr_strap_sampler import pmr_pkg::*; (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // Pin levels
  input  wire logic [DEV_ADDR_W-1:0] strapPins,
  // Latched result
  pmr_strap_if.sampler               strap
);

  pmr_strap_state_t st;       // Registered state
  pmr_strap_state_t next_st;  // Next state

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Three-stage chain; only stages two and three are compared
  always_comb begin
    next_st    = st;
    next_st.s1 = strapPins;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (!st.valid) begin
      // Level must hold a few cycles so a slow pin edge is not caught
      if (st.s2 != st.s3) begin
        next_st.cnt = 3'h0;
      end else if (st.cnt == 3'(STRAP_SETTLE_CYC)) begin
        next_st.devAddr = st.s3;
        next_st.valid   = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 3'h1;
      end
    end
  end

  // Registers; reset takes constants only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign strap.devAddr = st.devAddr;
  assign strap.valid   = st.valid;

endmodule
`default_nettype wire

// File: tb_phy_mgmt_register_bank.sv
// Self-checking bench for the management register bank.
// Assumes the controller model drives all strobes.
`timescale 1ns/1ns
`default_nettype none
module tb_phy_mgmt_register_bank;
  import pmr_pkg::*;
  logic                      clk, resetn, busy, rdValid, softResetPulse;
  logic                      rdStrobe, wrStrobe, vld;
  logic [4:0]                strap, devAddr;
  pmr_word_t [REG_COUNT-1:0] hwStatus, hwSetBits, ctrl;
  pmr_word_t                 rdData, wrData, got;
  pmr_addr_t                 sel;
  int                        errTotal, nCompared, cyc;

  pmr_register_bank #(.IDENT_HIGH(16'h1234), .IDENT_LOW(16'h5678)) u_dut (
    .clk(clk), .resetn(resetn),
    .addrStrapBit0Led(strap[0]), .addrStrapBit1Led(strap[1]),
    .addrStrapBit2Led(strap[2]), .addrStrapBit3Led(strap[3]),
    .addrStrapBit4Led(strap[4]), .registerSelectField(sel),
    .rdStrobe(rdStrobe), .wrStrobe(wrStrobe), .wrData(wrData), .busy(busy),
    .rdValid(rdValid), .rdData(rdData), .hwStatus(hwStatus),
    .hwSetBits(hwSetBits), .ctrlWord(ctrl), .deviceAddressBits(devAddr),
    .softResetPulse(softResetPulse));
  pmr_sta_model u_sta (.clk(clk), .busy(busy), .rdValid(rdValid),
    .rdData(rdData), .rdStrobe(rdStrobe), .wrStrobe(wrStrobe), .sel(sel),
    .wrData(wrData));

  // Clock and cycle ceiling
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errTotal++;
      wrapUp();
    end
  end

  task automatic chk(input pmr_word_t g, input pmr_word_t e);
    nCompared++;
    if (g !== e) begin
      errTotal++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Read with answer pulse and value checked
  task automatic rdc(input pmr_addr_t a, input pmr_word_t e);
    u_sta.rd(a, got, vld);
    chk({15'h0000, vld}, 16'h0001);
    chk(got, e);
    // Answer pulse falls, word stays
    @(posedge clk);
    #1;
    chk({15'h0000, rdValid}, 16'h0000);
    chk(rdData, e);
  endtask
  task automatic hw_reset(input logic [4:0] s);
    @(posedge clk);
    #1;
    strap  = s;
    resetn = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    resetn = 1'b1;
  endtask
  // Defaults after hardware reset, strap-derived fields
  task automatic t_defaults(input logic [4:0] s);
    rdc(ADDR_BASIC_CONTROL, (s == 5'h00) ? 16'h3400 : 16'h3000);
    rdc(ADDR_EXT_CTRL_ONE, {5'h00, s, 6'h00});
    chk({11'h000, devAddr}, {11'h000, s});
    rdc(ADDR_IDENT_HIGH, 16'h1234);
    rdc(ADDR_IDENT_LOW, 16'h5678);
    rdc(ADDR_NEG_ADVERTISE, 16'h0000);
  endtask
  task automatic t_rw();
    pmr_addr_t ra[3] = '{ADDR_NEG_ADVERTISE, ADDR_NP_TRANSMIT, ADDR_EXT_CTRL_TWO};
    for (int i = 0; i < 3; i++) begin
      u_sta.wr(ra[i], 16'h5a5a ^ 16'(i));
      rdc(ra[i], 16'h5a5a ^ 16'(i));
    end
    chk(ctrl[IDX_NP_TRANSMIT], 16'h5a5b);
  endtask
  task automatic t_ro();
    int sl[4] = '{5, 6, 8, 10};
    for (int i = 0; i < 4; i++) begin
      hwStatus[sl[i]] = 16'hbe00 + 16'(i);
      u_sta.wr(REG_ADDR[sl[i]], 16'h0000);
      rdc(REG_ADDR[sl[i]], 16'hbe00 + 16'(i));
    end
  endtask
  task automatic t_unmapped();
    u_sta.wr(ADDR_NEG_ADVERTISE, 16'h1111);
    for (int a = 0; a < 32; a++) begin
      if (a inside {[9:15], [20:31]}) begin
        u_sta.wr(5'(a), 16'hffff);
        rdc(5'(a), 16'hffff);
      end
    end
    rdc(ADDR_NEG_ADVERTISE, 16'h1111);
  endtask
  // Gated bit 1.6; override bit 16.15 survives an unmapped write, clears after one write
  task automatic t_override(input logic [4:0] s);
    u_sta.wr(ADDR_BASIC_STATUS, 16'h0040);
    rdc(ADDR_BASIC_STATUS, 16'h0000);
    u_sta.wr(ADDR_EXT_CTRL_ONE, {5'h10, s, 6'h00});
    rdc(ADDR_EXT_CTRL_ONE, {5'h10, s, 6'h00});
    rdc(ADDR_BASIC_STATUS, 16'h0000);
    u_sta.wr(5'h09, 16'hffff);
    u_sta.wr(ADDR_BASIC_STATUS, 16'h0040);
    rdc(ADDR_BASIC_STATUS, 16'h0040);
    rdc(ADDR_EXT_CTRL_ONE, {5'h00, s, 6'h00});
    u_sta.wr(ADDR_BASIC_STATUS, 16'h0000);
    rdc(ADDR_BASIC_STATUS, 16'h0040);
  endtask
  // Zero-only bit 18.0 set by the core
  task automatic t_w0();
    hwSetBits[11] = 16'h0001;
    @(posedge clk);
    #1;
    hwSetBits[11] = 16'h0000;
    u_sta.wr(ADDR_TEN_MEG, 16'hffff);
    rdc(ADDR_TEN_MEG, 16'hffff);
    u_sta.wr(ADDR_TEN_MEG, 16'hfffe);
    rdc(ADDR_TEN_MEG, 16'hfffe);
    u_sta.wr(ADDR_TEN_MEG, 16'hffff);
    rdc(ADDR_TEN_MEG, 16'hfffe);
  endtask
  task automatic t_soft(input logic [4:0] s);
    u_sta.wr(ADDR_NEG_ADVERTISE, 16'habcd);
    u_sta.wr(ADDR_BASIC_CONTROL, 16'hb000);
    chk({14'h0000, softResetPulse, busy}, 16'h0003);
    rdc(ADDR_NEG_ADVERTISE, 16'h0000);
    rdc(ADDR_BASIC_CONTROL, (s == 5'h00) ? 16'h3400 : 16'h3000);
  endtask

  task automatic wrapUp();
    $display("errors %0d compared %0d", errTotal, nCompared);
    if (errTotal == 0 && nCompared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence, second hardware reset with a new strap
  initial begin
    resetn    = 1'b0;
    strap     = 5'h0b;
    hwStatus  = '0;
    hwSetBits = '0;
    errTotal  = 0;
    nCompared = 0;
    cyc       = 0;
    hw_reset(5'h0b);
    t_defaults(5'h0b);
    t_rw();
    t_ro();
    t_unmapped();
    t_override(5'h0b);
    t_w0();
    t_soft(5'h0b);
    u_sta.wr(ADDR_NEG_ADVERTISE, 16'h4321);
    hw_reset(5'h00);
    t_defaults(5'h00);
    wrapUp();
  end
endmodule
`default_nettype wire
